// [include/mmx_map.vh]
// Purpose: Opcode, field and timing constants for the move/multiply subset
// Assumes: Instruction word 24 bits, data 16 bits
// Notes: Encodings are this block's own
`ifndef MMX_MAP_VH
`define MMX_MAP_VH
`define MMX_OP_MSB 23
`define MMX_OP_LSB 19
`define MMX_OP_LIT16 5'h01
`define MMX_OP_LIT8 5'h02
`define MMX_OP_DMOV_RD 5'h03
`define MMX_OP_DMOV_WR 5'h04
`define MMX_OP_PAG_LIT 5'h05
`define MMX_OP_PAG_REG 5'h06
`define MMX_OP_PREF_ST 5'h07
`define MMX_OP_MPY 5'h08
`define MMX_OP_MPY_SQ 5'h09
`define MMX_OP_MPY_NEG 5'h0a
`define MMX_OP_MSC 5'h0b
`define MMX_ACC_BIT 18
`define MMX_PAG_SEL_MSB 17
`define MMX_PAG_SEL_LSB 16
`define MMX_PAG_RD 2'h0
`define MMX_PAG_WR 2'h1
`define MMX_PAG_TB 2'h2
`define MMX_RD_LSB 0
`define MMX_RS_LSB 4
`define MMX_RT_LSB 8
`define MMX_LIT_LSB 4
`define MMX_RDP_W 10
`define MMX_WRP_W 9
`define MMX_TBP_W 8
`define MMX_DMOV_CYC 2'h2
`endif

// [verilog/mmx_mul.v]
// Purpose: Signed 16x16 product, sign extended to accumulator width
// Assumes: Combinational, used within one cycle
// Notes: Fractional scaling is left to the caller
`default_nettype none
module mmx_mul #(
  parameter DW = 16,
  parameter AW = 40
) (
  input wire [DW-1:0] i_a,
  input wire [DW-1:0] i_b,
  output wire [AW-1:0] o_prod
);
  wire signed [2*DW-1:0] p;
  assign p = $signed(i_a) * $signed(i_b);
  assign o_prod = {{(AW-2*DW){p[2*DW-1]}}, p};
endmodule
`default_nettype wire

// [verilog/mmx_sat.v]
// Purpose: Overflow and saturation detection for one accumulator result
// Assumes: Guard bits above bit 31, full range AW bits
// Notes: Overflow means guard bits differ from bit 31; saturation means
//   the full-width sum wrapped
`default_nettype none
module mmx_sat #(
  parameter AW = 40
) (
  input wire [AW-1:0] i_a,
  input wire [AW-1:0] i_b,
  input wire [AW-1:0] i_sum,
  input wire i_sub,
  output wire o_ovf,
  output wire o_sat
);
  wire bs;
  assign bs = i_b[AW-1] ^ i_sub;
  assign o_ovf = ~((&i_sum[AW-1:31]) | ~(|i_sum[AW-1:31]));
  assign o_sat = (i_a[AW-1] == bs) & (i_sum[AW-1] != i_a[AW-1]);
endmodule
`default_nettype wire

// [verilog/mmx_core.v]
// What this block does
// - A 16-bit literal load writes a work register in one cycle, no flags.
// - A byte literal load writes 8 bits of a work register in one cycle, no flags.
// - A pair-source double move copies Wn and Wn+1 out over two cycles, no flags.
// - A pair-dest double move writes Wn low and Wn+1 high over two cycles, no flags.
// - A literal page load into the read page register takes 10 bits in one cycle.
// - A literal page load into the write page register takes 9 bits in one cycle.
// - A literal page load into the table page register takes 8 bits in one cycle.
// - A page load from a work register takes only its low 10, 9 or 8 bits.
// - Multiply writes Wm*Wn to the chosen accumulator in one cycle, updating flags.
// - Square writes Wn*Wn to the chosen accumulator with the same flag update.
// - Negated multiply writes minus the product in one cycle, flags unchanged.
// - Multiply-subtract takes the product from the accumulator, updating flags.
// - Prefetch and store writes the other accumulator back in one cycle, no flags.
//
// Purpose: Executes the move, page-load and multiply subset of the core
// Assumes: One instruction offered per cycle with i_valid; o_busy stalls
// Notes: Each multiply, square or multiply-subtract overwrites the selected accumulator's flags
`default_nettype none
`include "mmx_map.vh"
module mmx_core #(
  parameter DW = 16,
  parameter AW = 40,
  parameter NREG = 16
) (
  input wire i_clk,
  input wire i_reset,
  input wire i_valid,
  input wire [23:0] i_instr,
  input wire [DW-1:0] i_pref_x,
  input wire [DW-1:0] i_pref_y,
  input wire i_pref_x_en,
  input wire i_pref_y_en,
  input wire [3:0] i_pref_x_dst,
  input wire [3:0] i_pref_y_dst,
  output reg o_busy,
  output reg o_done,
  output reg [DW-1:0] o_move_data,
  output reg o_move_valid,
  output reg o_wb_valid,
  output reg [DW-1:0] o_acc_write_back,
  output reg [`MMX_RDP_W-1:0] o_read_page_reg,
  output reg [`MMX_WRP_W-1:0] o_write_page_reg,
  output reg [`MMX_TBP_W-1:0] o_table_page_reg,
  output reg [AW-1:0] o_acc_a,
  output reg [AW-1:0] o_acc_b,
  output reg o_acc_a_overflow,
  output reg o_acc_b_overflow,
  output reg o_acc_any_overflow,
  output reg o_acc_a_saturated,
  output reg o_acc_b_saturated,
  output reg o_acc_any_saturated
);
  reg [DW-1:0] default_work_reg_q [0:NREG-1];
  reg [1:0] state_q;
  reg [3:0] dreg_q;
  reg [DW-1:0] dhi_q;
  reg dir_q;
  localparam ST_IDLE = 2'h0;
  localparam ST_DBL2 = 2'h1;

  function [3:0] fld;
    input [23:0] w;
    input integer lsb;
    begin
      fld = w[lsb +: 4];
    end
  endfunction

  wire [4:0] op;
  wire accsel;
  wire [3:0] rd;
  wire [3:0] rs;
  wire [3:0] rt;
  wire [DW-1:0] vs;
  wire [DW-1:0] vt;
  wire [DW-1:0] vs1;
  wire [AW-1:0] prod;
  wire [AW-1:0] cur;
  wire [AW-1:0] diff;
  wire ovf;
  wire sat;
  wire go;
  // The 16-bit literal spans bit 19, so both codes with [23:20] zero load it
  assign op = (i_instr[23:20] == 4'h0) ? `MMX_OP_LIT16 :
    i_instr[`MMX_OP_MSB:`MMX_OP_LSB];
  assign accsel = i_instr[`MMX_ACC_BIT];
  assign rd = fld(i_instr, `MMX_RD_LSB);
  assign rs = fld(i_instr, `MMX_RS_LSB);
  assign rt = fld(i_instr, `MMX_RT_LSB);
  assign vs = default_work_reg_q[rs];
  assign vs1 = default_work_reg_q[rs + 4'h1];
  assign vt = (op == `MMX_OP_MPY_SQ) ? vs : default_work_reg_q[rt];
  assign cur = accsel ? o_acc_b : o_acc_a;
  assign diff = cur - prod;
  assign go = i_valid & ~o_busy & (state_q == ST_IDLE);

  mmx_mul #(.DW(DW), .AW(AW)) u_mul (
    .i_a(vs),
    .i_b(vt),
    .o_prod(prod)
  );

  mmx_sat #(.AW(AW)) u_sat (
    .i_a(cur),
    .i_b(prod),
    .i_sum(diff),
    .i_sub(1'b1),
    .o_ovf(ovf),
    .o_sat(sat)
  );

  // Flag update shared by multiply and multiply-subtract
  task set_flags;
    input [AW-1:0] res;
    input s;
    reg o;
    begin
      o = ~((&res[AW-1:31]) | ~(|res[AW-1:31]));
      if (accsel) begin
        o_acc_b_overflow <= o;
        o_acc_b_saturated <= s;
        o_acc_any_overflow <= o | o_acc_a_overflow;
        o_acc_any_saturated <= s | o_acc_a_saturated;
      end else begin
        o_acc_a_overflow <= o;
        o_acc_a_saturated <= s;
        o_acc_any_overflow <= o | o_acc_b_overflow;
        o_acc_any_saturated <= s | o_acc_b_saturated;
      end
    end
  endtask

  integer k;
  always @(posedge i_clk) begin
    if (i_reset) begin
      for (k = 0; k < NREG; k = k + 1) begin
        default_work_reg_q[k] <= 16'h0000;
      end
      state_q <= ST_IDLE;
      dreg_q <= 4'h0;
      dhi_q <= 16'h0000;
      dir_q <= 1'b0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_move_data <= 16'h0000;
      o_move_valid <= 1'b0;
      o_wb_valid <= 1'b0;
      o_acc_write_back <= 16'h0000;
      o_read_page_reg <= 10'h000;
      o_write_page_reg <= 9'h000;
      o_table_page_reg <= 8'h00;
      o_acc_a <= 40'h0000000000;
      o_acc_b <= 40'h0000000000;
      o_acc_a_overflow <= 1'b0;
      o_acc_b_overflow <= 1'b0;
      o_acc_any_overflow <= 1'b0;
      o_acc_a_saturated <= 1'b0;
      o_acc_b_saturated <= 1'b0;
      o_acc_any_saturated <= 1'b0;
    end else begin
      o_done <= 1'b0;
      o_move_valid <= 1'b0;
      o_wb_valid <= 1'b0;
      case (state_q)
        ST_DBL2: begin
          // Second word of a double move
          if (dir_q) begin
            default_work_reg_q[dreg_q + 4'h1] <= dhi_q;
          end else begin
            o_move_data <= dhi_q;
            o_move_valid <= 1'b1;
          end
          state_q <= ST_IDLE;
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end
        default: begin
          if (go) begin
            o_done <= 1'b1;
            // Prefetches land in the same cycle as the arithmetic
            if ((op == `MMX_OP_MPY || op == `MMX_OP_MPY_SQ ||
                op == `MMX_OP_MPY_NEG || op == `MMX_OP_MSC ||
                op == `MMX_OP_PREF_ST)) begin
              if (i_pref_x_en) default_work_reg_q[i_pref_x_dst] <= i_pref_x;
              if (i_pref_y_en) default_work_reg_q[i_pref_y_dst] <= i_pref_y;
            end
            case (op)
              `MMX_OP_LIT16: default_work_reg_q[rd] <= i_instr[`MMX_LIT_LSB +: 16];
              `MMX_OP_LIT8: default_work_reg_q[rd][7:0] <= i_instr[`MMX_LIT_LSB +: 8];
              `MMX_OP_DMOV_RD: begin
                o_move_data <= vs;
                o_move_valid <= 1'b1;
                dhi_q <= vs1;
                dir_q <= 1'b0;
                o_done <= 1'b0;
                o_busy <= 1'b1;
                state_q <= ST_DBL2;
              end
              `MMX_OP_DMOV_WR: begin
                default_work_reg_q[rd] <= i_pref_x;
                dhi_q <= i_pref_y;
                dreg_q <= rd;
                dir_q <= 1'b1;
                o_done <= 1'b0;
                o_busy <= 1'b1;
                state_q <= ST_DBL2;
              end
              `MMX_OP_PAG_LIT, `MMX_OP_PAG_REG: begin
                case (i_instr[`MMX_PAG_SEL_MSB:`MMX_PAG_SEL_LSB])
                  `MMX_PAG_RD: o_read_page_reg <= (op == `MMX_OP_PAG_LIT) ?
                    i_instr[`MMX_LIT_LSB +: 10] : vs[9:0];
                  `MMX_PAG_WR: o_write_page_reg <= (op == `MMX_OP_PAG_LIT) ?
                    i_instr[`MMX_LIT_LSB +: 9] : vs[8:0];
                  `MMX_PAG_TB: o_table_page_reg <= (op == `MMX_OP_PAG_LIT) ?
                    i_instr[`MMX_LIT_LSB +: 8] : vs[7:0];
                  default: o_done <= 1'b1;
                endcase
              end
              `MMX_OP_PREF_ST: begin
                o_acc_write_back <= accsel ? o_acc_a[31:16] :
                  o_acc_b[31:16];
                o_wb_valid <= 1'b1;
              end
              `MMX_OP_MPY, `MMX_OP_MPY_SQ: begin
                if (accsel) o_acc_b <= prod;
                else o_acc_a <= prod;
                set_flags(prod, 1'b0);
              end
              `MMX_OP_MPY_NEG: begin
                if (accsel) o_acc_b <= 40'h0000000000 - prod;
                else o_acc_a <= 40'h0000000000 - prod;
              end
              `MMX_OP_MSC: begin
                if (accsel) o_acc_b <= diff;
                else o_acc_a <= diff;
                set_flags(diff, sat);
                o_acc_write_back <= accsel ? o_acc_a[31:16] :
                  o_acc_b[31:16];
                o_wb_valid <= 1'b1;
              end
              default: o_done <= 1'b0;
            endcase
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [dv/mmx_core_props.sv]
// Purpose: Port timing checks for the move and multiply subset core
// Assumes: One clock, synchronous reset
// Notes: Work registers are internal, so data checks sit in the bench
`default_nettype none
`include "mmx_map.vh"
module mmx_core_props #(
  parameter DW = 16,
  parameter AW = 40
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_valid,
  input wire logic [23:0] i_instr,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_move_valid,
  input wire logic o_wb_valid,
  input wire logic [DW-1:0] o_acc_write_back,
  input wire logic [9:0] o_read_page_reg,
  input wire logic [8:0] o_write_page_reg,
  input wire logic [7:0] o_table_page_reg,
  input wire logic [AW-1:0] o_acc_a,
  input wire logic [AW-1:0] o_acc_b,
  input wire logic o_acc_a_overflow,
  input wire logic o_acc_b_overflow,
  input wire logic o_acc_any_overflow,
  input wire logic o_acc_a_saturated,
  input wire logic o_acc_b_saturated,
  input wire logic o_acc_any_saturated
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  wire [4:0] op = (i_instr[23:20] == 4'h0) ? `MMX_OP_LIT16 :
    i_instr[23:19];
  wire tk = i_valid && !o_busy;
  wire pg = tk && op == `MMX_OP_PAG_LIT;
  wire [9:0] lit = i_instr[13:4];
  wire known = op != 5'h00 && op < 5'h0c;
  wire dm = op == `MMX_OP_DMOV_RD || op == `MMX_OP_DMOV_WR;
  // Neither the double moves nor the negated multiply may touch a flag
  wire nf = tk && known && (op < `MMX_OP_MPY || op == `MMX_OP_MPY_NEG);
  wire [15:0] oth = i_instr[18] ? o_acc_a[31:16] : o_acc_b[31:16];
  wire [5:0] fl = {o_acc_a_overflow, o_acc_b_overflow, o_acc_any_overflow,
    o_acc_a_saturated, o_acc_b_saturated, o_acc_any_saturated};
  property p_one;
    tk && known && !dm |=> o_done && !o_busy;
  endproperty
  a_one: assert property (p_one) else $error("late done");
  property p_dmr;
    tk && op == `MMX_OP_DMOV_RD |=> o_busy && o_move_valid && !o_done
      ##1 !o_busy && o_move_valid && o_done;
  endproperty
  a_dmr: assert property (p_dmr) else $error("pair read timing");
  property p_dmw;
    tk && op == `MMX_OP_DMOV_WR |=> o_busy && !o_done ##1 o_done;
  endproperty
  a_dmw: assert property (p_dmw) else $error("pair write timing");
  property p_nfl;
    nf |=> $stable(fl);
  endproperty
  a_nfl: assert property (p_nfl) else $error("flags moved");
  property p_prd;
    pg && i_instr[17:16] == `MMX_PAG_RD |=> o_read_page_reg == $past(lit);
  endproperty
  a_prd: assert property (p_prd) else $error("read page");
  property p_pwr;
    pg && i_instr[17:16] == `MMX_PAG_WR
      |=> {1'b0, o_write_page_reg} == ($past(lit) & 10'h1ff);
  endproperty
  a_pwr: assert property (p_pwr) else $error("write page");
  property p_ptb;
    pg && i_instr[17:16] == `MMX_PAG_TB
      |=> {2'h0, o_table_page_reg} == ($past(lit) & 10'h0ff);
  endproperty
  a_ptb: assert property (p_ptb) else $error("table page");
  property p_awb;
    tk && op == `MMX_OP_PREF_ST
      |=> o_wb_valid && o_acc_write_back == $past(oth);
  endproperty
  a_awb: assert property (p_awb) else $error("write back");
  property p_sel;
    tk && op == `MMX_OP_MPY && !i_instr[18] |=> $stable(o_acc_b);
  endproperty
  a_sel: assert property (p_sel) else $error("wrong acc");
  property p_any;
    o_acc_any_overflow == (o_acc_a_overflow || o_acc_b_overflow);
  endproperty
  a_any: assert property (p_any) else $error("combined flag");
endmodule
`default_nettype wire

// [dv/mmx_core_tb.sv]
// Purpose: Directed bench for the move and multiply subset core
// Assumes: 40 MHz clock, reset held 20 cycles
// Notes: Products are checked as plain signed, no fractional shift
`default_nettype none
`include "mmx_map.vh"
module mmx_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0, i_reset = 1, i_valid = 0, xe = 0;
  logic [23:0] ins = 0;
  logic [15:0] px = 0, py = 0;
  wire bsy, dn, mv, wv;
  wire [15:0] md, wb;
  wire [9:0] pr;
  wire [8:0] pw;
  wire [7:0] pt;
  wire [39:0] aa, ab;
  wire [5:0] fl;
  int fails = 0, compares = 0, cyc = 0;
  mmx_core i_mmx_core (.i_clk(i_clk), .i_reset(i_reset), .i_valid(i_valid),
    .i_instr(ins), .i_pref_x(px), .i_pref_y(py), .i_pref_x_en(xe),
    .i_pref_y_en(xe), .i_pref_x_dst(4'h6), .i_pref_y_dst(4'h7),
    .o_busy(bsy), .o_done(dn), .o_move_data(md), .o_move_valid(mv),
    .o_wb_valid(wv), .o_acc_write_back(wb), .o_read_page_reg(pr),
    .o_write_page_reg(pw), .o_table_page_reg(pt), .o_acc_a(aa),
    .o_acc_b(ab), .o_acc_a_overflow(fl[5]), .o_acc_b_overflow(fl[4]),
    .o_acc_any_overflow(fl[3]), .o_acc_a_saturated(fl[2]),
    .o_acc_b_saturated(fl[1]), .o_acc_any_saturated(fl[0]));
  initial forever #12.5 i_clk = ~i_clk;
  task automatic report_and_stop;
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      report_and_stop;
    end
  end
  task automatic chk(string n, logic [39:0] e, logic [39:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  function automatic logic [23:0] mk(logic [4:0] o, logic a, logic [3:0] m,
    logic [3:0] n);
    return {o, a, 6'h0, m, n, n};
  endfunction
  // Valid stays up between requests; a busy edge ignores the held word
  task automatic go(logic [23:0] w);
    ins = w;
    i_valid = 1;
    @(posedge i_clk);
    #1;
  endtask
  task automatic t_wr(logic [3:0] n, logic [15:0] lo, logic [15:0] hi);
    px = lo;
    py = hi;
    go(mk(`MMX_OP_DMOV_WR, 0, n, n));
    chk("wbusy", 1, bsy);
    @(posedge i_clk);
    #1;
    chk("wdone", 1, dn);
  endtask
  task automatic t_rd(logic [3:0] n, logic [15:0] lo, logic [15:0] hi);
    go(mk(`MMX_OP_DMOV_RD, 0, n, n));
    chk("low", lo, md);
    @(posedge i_clk);
    #1;
    chk("high", hi, md);
  endtask
  task automatic t_lit;
    t_wr(2, 16'h1111, 16'h2222);
    go({4'h0, 16'h0a5c, 4'h2});
    go({`MMX_OP_LIT8, 19'h0} | {8'h3e, 4'h2});
    chk("ldone", 1, dn);
    t_rd(2, 16'h0a3e, 16'h2222);
  endtask
  task automatic t_page;
    for (int s = 0; s < 3; s++) go({`MMX_OP_PAG_LIT, 1'b0, 2'(s), 16'h3a50});
    chk("plit", {10'h3a5, 9'h1a5, 8'ha5}, {pr, pw, pt});
    for (int s = 0; s < 3; s++) go({`MMX_OP_PAG_REG, 1'b0, 2'(s), 16'h0222});
    chk("preg", {10'h23e, 9'h03e, 8'h3e}, {pr, pw, pt});
  endtask
  task automatic t_mul;
    t_wr(0, 16'h8000, 16'h7fff);
    go(mk(`MMX_OP_MPY_SQ, 0, 0, 0));
    chk("square", 40'h0040000000, aa);
    go(mk(`MMX_OP_MSC, 0, 1, 0));
    chk("msc", 40'h007fff8000, aa);
    chk("mscfl0", 6'b000000, fl);
    go(mk(`MMX_OP_MSC, 0, 1, 0));
    chk("msc2", 40'h00bfff0000, aa);
    chk("mscfl", 6'b101000, fl);
    go(mk(`MMX_OP_MPY_NEG, 1, 1, 0));
    chk("neg", 40'h003fff8000, ab);
    chk("negfl", 6'b101000, fl);
    go(mk(`MMX_OP_MPY, 1, 1, 1));
    chk("mpy", 40'h003fff0001, ab);
    chk("akept", 40'h00bfff0000, aa);
  endtask
  task automatic t_pref;
    px = 16'h0bad;
    py = 16'h0c0d;
    xe = 1;
    go(mk(`MMX_OP_PREF_ST, 0, 0, 0));
    xe = 0;
    chk("wb", {1'b1, 16'h3fff}, {wv, wb});
    t_rd(6, 16'h0bad, 16'h0c0d);
    go(24'hf80000);
    chk("refuse", 0, dn);
  endtask
  initial begin
    repeat (20) @(posedge i_clk);
    #1;
    i_reset = 0;
    chk("reset", 0, aa);
    chk("rstfl", 0, {pr, fl});
    t_lit;
    t_page;
    t_mul;
    t_pref;
    report_and_stop;
  end
endmodule
bind mmx_core mmx_core_props #(.DW(DW), .AW(AW)) i_mmx_core_props (
  .i_clk(i_clk), .i_reset(i_reset), .i_valid(i_valid), .i_instr(i_instr),
  .o_busy(o_busy), .o_done(o_done), .o_move_valid(o_move_valid),
  .o_wb_valid(o_wb_valid), .o_acc_write_back(o_acc_write_back),
  .o_read_page_reg(o_read_page_reg), .o_write_page_reg(o_write_page_reg),
  .o_table_page_reg(o_table_page_reg), .o_acc_a(o_acc_a), .o_acc_b(o_acc_b),
  .o_acc_a_overflow(o_acc_a_overflow), .o_acc_b_overflow(o_acc_b_overflow),
  .o_acc_any_overflow(o_acc_any_overflow),
  .o_acc_a_saturated(o_acc_a_saturated),
  .o_acc_b_saturated(o_acc_b_saturated),
  .o_acc_any_saturated(o_acc_any_saturated));
`default_nettype wire
